// file: verilog/dgc_pkg.sv
// constants and types shared by the dma global control block
package dgc_pkg;
	// register map, byte addresses
	localparam logic [7:0] DGC_OFS_GLOBAL = 8'h00;
	localparam logic [3:0] DGC_CH0_PAGE   = 4'h1;
	localparam logic [3:0] DGC_CH1_PAGE   = 4'h2;
	localparam logic [3:0] DGC_OFS_CTRL   = 4'h0;
	localparam logic [3:0] DGC_OFS_COUNT  = 4'h4;
	localparam logic [3:0] DGC_OFS_SRC    = 4'h8;
	localparam logic [3:0] DGC_OFS_STAT   = 4'hc;
	// global control fields
	localparam int unsigned DGC_GC_MASTER = 0;
	localparam int unsigned DGC_GC_NMI    = 1;
	localparam int unsigned DGC_GC_FAULT  = 2;
	localparam int unsigned DGC_GC_ORDER  = 3;
	// channel control fields
	localparam int unsigned DGC_CC_ENABLE = 0;
	localparam int unsigned DGC_CC_TEND   = 1;
	localparam int unsigned DGC_CC_IRQEN  = 2;
	localparam int unsigned DGC_CC_SINGLE = 3;
	localparam int unsigned DGC_CC_ACKPH  = 4;
	localparam int unsigned DGC_CC_AUTO   = 5;
	// channel status fields
	localparam int unsigned DGC_ST_ACTIVE = 0;
	localparam int unsigned DGC_ST_REQ    = 1;
	// widths and reset values
	localparam int unsigned DGC_CW        = 24;
	localparam logic [31:0] DGC_GLOBAL_RST = 32'h00000000;
	localparam logic [5:0]  DGC_CTRL_RST   = 6'h00;
	localparam logic [23:0] DGC_COUNT_RST  = 24'h000000;
	localparam logic [1:0]  DGC_SRC_RST    = 2'h0;
	// request source codes
	localparam logic [1:0] DGC_RS_EXT = 2'h0;
	localparam logic [1:0] DGC_RS_RX  = 2'h1;
	localparam logic [1:0] DGC_RS_TX  = 2'h2;
	// transfer unit phases
	typedef enum logic [3:0] {
		DGC_IDLE   = 4'b0001,
		DGC_READ   = 4'b0010,
		DGC_WRITE  = 4'b0100,
		DGC_SINGLE = 4'b1000
	} dgc_phase_t;
endpackage : dgc_pkg

// file: verilog/dgc_link_if.sv
// carrier between the control core, request selector and arbiter
`timescale 1ns/1ps
interface dgc_link_if;
	logic [1:0]      auto_rq;
	logic [1:0][1:0] src_sel;
	logic [1:0]      req_raw;
	logic            order_sel;
	logic [1:0]      arb_req;
	logic            grant_valid;
	logic            grant_ch;
	logic            done_pulse;
	logic            done_ch;
	modport ctl (output auto_rq, src_sel, order_sel, arb_req, done_pulse, done_ch,
		input req_raw, grant_valid, grant_ch);
	modport reqsrc (input auto_rq, src_sel, output req_raw);
	modport arb (input order_sel, arb_req, done_pulse, done_ch, output grant_valid, grant_ch);
endinterface : dgc_link_if

// file: verilog/dgc_req_sel.sv
// per-channel request source selection and request pin synchronisers
`timescale 1ns/1ps
module dgc_req_sel import dgc_pkg::*; (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	// request sources
	input  wire logic [1:0] ext_request_pin,
	input  wire logic       serial_rx_full_req,
	input  wire logic       serial_tx_empty_req,
	// to the control core
	dgc_link_if.reqsrc      lk
);
	typedef struct packed {
		logic [1:0][2:0] sync;
		logic [1:0]      lvl;
	} dgc_req_state_t;

	dgc_req_state_t s_q;
	dgc_req_state_t s_d;

	always_comb begin
		s_d = s_q;
		for (int c = 0; c < 2; c++) begin
			s_d.sync[c] = {s_q.sync[c][1:0], ext_request_pin[c]};
			// stage one feeds only stage two
			if (s_q.sync[c][1] == s_q.sync[c][2]) begin
				s_d.lvl[c] = s_q.sync[c][2];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// request need not come from source or destination
	for (genvar g = 0; g < 2; g++) begin : g_src
		assign lk.req_raw[g] = lk.auto_rq[g] ? 1'b1 :
			(lk.src_sel[g] == DGC_RS_EXT) ? s_q.lvl[g] :
			(lk.src_sel[g] == DGC_RS_RX)  ? serial_rx_full_req :
			(lk.src_sel[g] == DGC_RS_TX)  ? serial_tx_empty_req : 1'b0;
	end
endmodule : dgc_req_sel

// file: verilog/dgc_arb.sv
// two-channel arbiter, fixed or round-robin order
`timescale 1ns/1ps
module dgc_arb import dgc_pkg::*; (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic reset_n,
	// from the control core
	dgc_link_if.arb   lk
);
	typedef struct packed {
		logic rr_hi;
	} dgc_arb_state_t;

	dgc_arb_state_t s_q;
	dgc_arb_state_t s_d;

	always_comb begin
		s_d = s_q;
		// finished channel drops to the bottom
		if (lk.done_pulse && lk.order_sel) begin
			s_d.rr_hi = ~lk.done_ch;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign lk.grant_valid = |lk.arb_req;
	assign lk.grant_ch = (lk.arb_req == 2'b11) ? (lk.order_sel & s_q.rr_hi) :
		lk.arb_req[1];

	a_rr_rotate: assert property (@(posedge ref_clk) disable iff (!reset_n)
		lk.done_pulse && lk.order_sel ##1 lk.arb_req == 2'b11
		|-> lk.grant_ch != $past(lk.done_ch))
		else $error("round-robin did not rotate");
endmodule : dgc_arb

// file: verilog/dgc_top.sv
// dma global control, transfer flow and request handling for two channels
`timescale 1ns/1ps
module dgc_top import dgc_pkg::*; (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	// power modes
	input  wire logic        standby,
	input  wire logic        module_standby,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// events and requests
	input  wire logic        nmi_in,
	input  wire logic [1:0]  ext_request_pin,
	input  wire logic        serial_rx_full_req,
	input  wire logic        serial_tx_empty_req,
	// transfer bus side
	output logic             bus_rd_req,
	output logic             bus_wr_req,
	output logic             bus_single,
	output logic             bus_chan,
	output logic             bus_dev_to_mem,
	output logic      [1:0]  ext_ack_strobe,
	input  wire logic        bus_done,
	input  wire logic        bus_addr_err,
	input  wire logic        bus_target_excluded,
	// end of transfer
	output logic      [1:0]  finish_interrupt
);
	typedef struct packed {
		logic                   order_sel;
		logic                   addr_fault;
		logic                   nmi_flag;
		logic                   master;
		logic                   fault_armed;
		logic                   nmi_armed;
		logic [1:0]             tend_armed;
		logic [1:0]             ch_en;
		logic [1:0]             tend;
		logic [1:0]             irq_en;
		logic [1:0]             single;
		logic [1:0]             ackph;
		logic [1:0]             auto_rq;
		logic [1:0][1:0]        src_sel;
		logic [1:0][DGC_CW-1:0] count;
		dgc_phase_t             phase;
		logic                   cur_ch;
		logic                   cur_single;
		logic                   cur_ackph;
		logic [31:0]            rdata;
	} dgc_top_state_t;

	dgc_top_state_t s_q;
	dgc_top_state_t s_d;
	dgc_link_if     lk ();

	logic [1:0] ch_ok;
	logic [1:0] page_hit;
	logic       active;
	logic       abort;
	logic       unit_start;
	logic       unit_done;
	logic [31:0] global_word;

	dgc_req_sel u_req (
		.ref_clk             (ref_clk),
		.reset_n             (reset_n),
		.ext_request_pin     (ext_request_pin),
		.serial_rx_full_req  (serial_rx_full_req),
		.serial_tx_empty_req (serial_tx_empty_req),
		.lk                  (lk)
	);

	dgc_arb u_arb (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.lk      (lk)
	);

	for (genvar g = 0; g < 2; g++) begin : g_ch
		assign ch_ok[g] = s_q.ch_en[g] & s_q.master & ~s_q.tend[g] & ~s_q.nmi_flag
			& ~s_q.addr_fault & ~module_standby & (s_q.count[g] != '0);
		assign lk.arb_req[g] = ch_ok[g] & lk.req_raw[g];
		assign page_hit[g] = reg_addr[7:4] == ((g == 0) ? DGC_CH0_PAGE : DGC_CH1_PAGE);
		assign lk.auto_rq[g] = s_q.auto_rq[g];
		assign lk.src_sel[g] = s_q.src_sel[g];
		assign finish_interrupt[g] = s_q.tend[g] & s_q.irq_en[g];
		// single mode strobes for the whole cycle; dual picks read or write phase
		assign ext_ack_strobe[g] = (s_q.cur_ch == g) & ((s_q.phase == DGC_SINGLE)
			| ((s_q.phase == DGC_READ) & ~s_q.cur_ackph)
			| ((s_q.phase == DGC_WRITE) & s_q.cur_ackph));
	end

	assign lk.order_sel  = s_q.order_sel;
	assign active        = s_q.phase != DGC_IDLE;
	// clearing enable or master gate cuts a unit short
	assign abort         = active & ~(s_q.ch_en[s_q.cur_ch] & s_q.master);
	assign unit_start    = (s_q.phase == DGC_IDLE) & lk.grant_valid;
	assign unit_done     = bus_done & ~abort & ((s_q.phase == DGC_WRITE) | (s_q.phase == DGC_SINGLE));
	assign lk.done_pulse = unit_done;
	assign lk.done_ch    = s_q.cur_ch;
	assign global_word   = {28'h0000000, s_q.order_sel, s_q.addr_fault, s_q.nmi_flag, s_q.master};

	always_comb begin
		s_d = s_q;
		s_d.rdata = '0;
		// reserved bits of a global write are dropped
		if (reg_wr && reg_addr == DGC_OFS_GLOBAL) begin
			s_d.order_sel = reg_wdata[DGC_GC_ORDER];
			s_d.master = reg_wdata[DGC_GC_MASTER];
			if (!reg_wdata[DGC_GC_FAULT] && s_q.fault_armed) begin
				s_d.addr_fault = 1'b0;
			end
			if (!reg_wdata[DGC_GC_NMI] && s_q.nmi_armed) begin
				s_d.nmi_flag = 1'b0;
			end
			s_d.fault_armed = 1'b0;
			s_d.nmi_armed = 1'b0;
		end
		if (reg_rd && reg_addr == DGC_OFS_GLOBAL) begin
			s_d.rdata = global_word;
			s_d.fault_armed = s_q.fault_armed | s_q.addr_fault;
			s_d.nmi_armed = s_q.nmi_armed | s_q.nmi_flag;
		end
		for (int c = 0; c < 2; c++) begin
			if (reg_wr && page_hit[c]) begin
				unique case (reg_addr[3:0])
					DGC_OFS_CTRL: begin
						s_d.ch_en[c] = reg_wdata[DGC_CC_ENABLE];
						s_d.irq_en[c] = reg_wdata[DGC_CC_IRQEN];
						s_d.single[c] = reg_wdata[DGC_CC_SINGLE];
						s_d.ackph[c] = reg_wdata[DGC_CC_ACKPH];
						s_d.auto_rq[c] = reg_wdata[DGC_CC_AUTO];
						if (!reg_wdata[DGC_CC_TEND] && s_q.tend_armed[c]) begin
							s_d.tend[c] = 1'b0;
						end
						s_d.tend_armed[c] = 1'b0;
					end
					DGC_OFS_COUNT: s_d.count[c] = reg_wdata[DGC_CW-1:0];
					DGC_OFS_SRC:   s_d.src_sel[c] = reg_wdata[1:0];
					default: ;
				endcase
			end
			if (reg_rd && page_hit[c]) begin
				unique case (reg_addr[3:0])
					DGC_OFS_CTRL: begin
						s_d.rdata = {26'h0, s_q.auto_rq[c], s_q.ackph[c], s_q.single[c],
							s_q.irq_en[c], s_q.tend[c], s_q.ch_en[c]};
						s_d.tend_armed[c] = s_q.tend_armed[c] | s_q.tend[c];
					end
					DGC_OFS_COUNT: s_d.rdata = {8'h00, s_q.count[c]};
					DGC_OFS_SRC:   s_d.rdata = {30'h0, s_q.src_sel[c]};
					DGC_OFS_STAT:  s_d.rdata = {30'h0, lk.req_raw[c],
						active && (s_q.cur_ch == c)};
					default: ;
				endcase
			end
		end
		// transfer unit sequencing; hardware events override the writes above
		unique case (s_q.phase)
			DGC_IDLE: begin
				if (lk.grant_valid) begin
					s_d.cur_ch = lk.grant_ch;
					s_d.cur_single = s_q.single[lk.grant_ch];
					s_d.cur_ackph = s_q.ackph[lk.grant_ch];
					if (s_q.single[lk.grant_ch]) begin
						s_d.phase = DGC_SINGLE;
					end else if (bus_target_excluded) begin
						s_d.addr_fault = 1'b1;
					end else begin
						s_d.phase = DGC_READ;
					end
				end
			end
			DGC_READ: begin
				// a fault or nmi here still lets the write complete
				if (abort) begin
					s_d.phase = DGC_IDLE;
				end else if (bus_done) begin
					s_d.phase = DGC_WRITE;
				end
			end
			DGC_WRITE, DGC_SINGLE: begin
				if (abort) begin
					s_d.phase = DGC_IDLE;
				end else if (bus_done) begin
					s_d.count[s_q.cur_ch] = s_q.count[s_q.cur_ch] - DGC_CW'(1);
					if (s_q.count[s_q.cur_ch] == DGC_CW'(1)) begin
						s_d.tend[s_q.cur_ch] = 1'b1;
					end
					s_d.phase = DGC_IDLE;
				end
			end
			default: s_d.phase = DGC_IDLE;
		endcase
		if (bus_addr_err && active) begin
			s_d.addr_fault = 1'b1;
		end
		if (nmi_in) begin
			s_d.nmi_flag = 1'b1;
		end
	end

	// standby clears this block's state like reset; the arbiter and request synchronisers keep theirs
	always_ff @(posedge ref_clk) begin
		if (!reset_n || standby) begin
			s_q <= '0;
			s_q.phase <= DGC_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata      = s_q.rdata;
	assign bus_rd_req     = s_q.phase == DGC_READ;
	assign bus_wr_req     = s_q.phase == DGC_WRITE;
	assign bus_single     = s_q.phase == DGC_SINGLE;
	assign bus_chan       = s_q.cur_ch;
	assign bus_dev_to_mem = s_q.cur_single & s_q.cur_ackph;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n || standby);

	a_reserved_zero: assert property (reg_rd && reg_addr == DGC_OFS_GLOBAL |=> reg_rdata[31:4] == 28'h0000000)
		else $error("reserved global bits not zero");
	a_standby_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
		standby |=> !s_q.master && !s_q.order_sel && !active)
		else $error("standby did not clear state");
	a_fixed_order: assert property (unit_start && !s_q.order_sel && lk.arb_req == 2'b11 |=> s_q.cur_ch == 1'b0)
		else $error("fixed order did not favour channel 0");
	a_start_gate: assert property (unit_start |-> s_q.master && !s_q.nmi_flag && !s_q.addr_fault && !s_q.tend[lk.grant_ch])
		else $error("unit started while blocked");
	a_nmi_sets: assert property (nmi_in |=> s_q.nmi_flag [*2])
		else $error("nmi flag not held");
	a_fault_finish: assert property (s_q.phase == DGC_READ && bus_done && !abort |=> s_q.phase == DGC_WRITE)
		else $error("unit in progress did not complete");
	a_master_abort: assert property (active && !s_q.master |=> !active)
		else $error("master gate clear did not abort");
	a_count_dec: assert property (unit_done && !s_q.cur_ch && !reg_wr |=> s_q.count[0] == $past(s_q.count[0]) - DGC_CW'(1))
		else $error("count not decremented");
	a_end_irq: assert property (unit_done && s_q.count[s_q.cur_ch] == DGC_CW'(1) && s_q.irq_en[s_q.cur_ch] && !reg_wr
		|=> finish_interrupt[$past(s_q.cur_ch)])
		else $error("end interrupt missing");
	a_dual_ack: assert property (s_q.phase == DGC_READ |-> ext_ack_strobe[s_q.cur_ch] == !s_q.cur_ackph)
		else $error("dual acknowledge phase wrong");

	c_normal_end: cover property (unit_done && s_q.count[s_q.cur_ch] == DGC_CW'(1));
	c_rr_ch1: cover property (unit_start && s_q.order_sel && lk.grant_ch && lk.arb_req == 2'b11);
	c_abort: cover property (abort);
	c_nmi_active: cover property (nmi_in && active ##[1:20] unit_done);
endmodule : dgc_top

// file: tb/dgc_bus_model.sv
// behavioural memory and device side answering the transfer bus
`timescale 1ns/1ps
module dgc_bus_model (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	// transfer bus
	input  wire logic       bus_rd_req,
	input  wire logic       bus_wr_req,
	input  wire logic       bus_single,
	output logic            bus_done,
	output logic            bus_addr_err,
	// test controls
	input  wire logic [3:0] lat,
	input  wire logic       err_arm
);
	logic [3:0] cnt_q;
	wire        act = bus_rd_req | bus_wr_req | bus_single;
	// one done pulse per phase; the phase moves on at that same edge
	always @(posedge ref_clk) begin
		if (!reset_n || !act || bus_done) begin
			cnt_q        <= 4'h0;
			bus_done     <= 1'b0;
			bus_addr_err <= 1'b0;
		end else if (cnt_q >= lat) begin
			bus_done     <= 1'b1;
			// error only when the bench arms it, rides with the done pulse
			bus_addr_err <= err_arm;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule : dgc_bus_model

// file: tb/dgc_top_tb.sv
// self-checking bench for the dma global control block
`timescale 1ns/1ps
module dgc_top_tb import dgc_pkg::*; ;
	logic        ref_clk, reset_n, standby, module_standby, reg_wr, reg_rd, nmi_in;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [1:0]  ext_request_pin, ext_ack_strobe, finish_interrupt, sh_single, sh_ackph;
	logic        serial_rx_full_req, serial_tx_empty_req, bus_rd_req, bus_wr_req, bus_single;
	logic        bus_chan, bus_dev_to_mem, bus_done, bus_addr_err, bus_target_excluded;
	logic        err_arm, busy_q;
	logic [3:0]  lat;
	logic        seq[$];
	int          fail_count, samples_checked, n;
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	dgc_top dgc_top_i (.ref_clk(ref_clk), .reset_n(reset_n), .standby(standby),
		.module_standby(module_standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nmi_in(nmi_in),
		.ext_request_pin(ext_request_pin), .serial_rx_full_req(serial_rx_full_req),
		.serial_tx_empty_req(serial_tx_empty_req), .bus_rd_req(bus_rd_req),
		.bus_wr_req(bus_wr_req), .bus_single(bus_single), .bus_chan(bus_chan),
		.bus_dev_to_mem(bus_dev_to_mem), .ext_ack_strobe(ext_ack_strobe), .bus_done(bus_done),
		.bus_addr_err(bus_addr_err), .bus_target_excluded(bus_target_excluded),
		.finish_interrupt(finish_interrupt));
	dgc_bus_model dgc_bus_model_i (.ref_clk(ref_clk), .reset_n(reset_n),
		.bus_rd_req(bus_rd_req), .bus_wr_req(bus_wr_req), .bus_single(bus_single),
		.bus_done(bus_done), .bus_addr_err(bus_addr_err), .lat(lat), .err_arm(err_arm));
	task automatic end_of_test();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [7:0] ra(input logic ch, input logic [3:0] o);
		return {ch ? DGC_CH1_PAGE : DGC_CH0_PAGE, o};
	endfunction : ra
	function automatic logic [1:0] ack_exp(input logic ch, input logic r, input logic w,
		input logic s);
		return (s | (sh_ackph[ch] ? w : r)) ? (ch ? 2'b10 : 2'b01) : 2'b00;
	endfunction : ack_exp
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		chk(reg_rdata, e);
	endtask : rc
	task automatic setup(input logic ch, input logic [31:0] cnt, input logic [31:0] ctl,
		input logic [1:0] s);
		wr(ra(ch, DGC_OFS_COUNT), cnt);
		wr(ra(ch, DGC_OFS_SRC), {30'h0, s});
		sh_single[ch] = ctl[DGC_CC_SINGLE];
		sh_ackph[ch]  = ctl[DGC_CC_ACKPH];
		wr(ra(ch, DGC_OFS_CTRL), ctl);
	endtask : setup
	// reading arms the flag, the following zero write clears it
	task automatic clr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		wr(a, v);
	endtask : clr
	// quiet bus for 16 cycles in a row counts as settled
	task automatic wait_idle();
		int q, t;
		q = 0;
		for (t = 0; t < 3000 && q < 16; t++) begin
			@(posedge ref_clk);
			q = (bus_rd_req | bus_wr_req | bus_single) ? 0 : q + 1;
		end
		chk(q, 32'h10);
	endtask : wait_idle
	task automatic wait_start();
		int t;
		for (t = 0; t < 300 && seq.size() == 0; t++) @(posedge ref_clk);
	endtask : wait_start
	always @(posedge ref_clk) begin
		if (reset_n && (bus_rd_req | bus_single) && !busy_q) seq.push_back(bus_chan);
		busy_q <= reset_n & (bus_rd_req | bus_wr_req | bus_single);
		if (reset_n && (bus_rd_req | bus_wr_req | bus_single)) begin
			chk({bus_single, ext_ack_strobe}, {sh_single[bus_chan],
				ack_exp(bus_chan, bus_rd_req, bus_wr_req, bus_single)});
			if (bus_single) chk(bus_dev_to_mem, sh_ackph[bus_chan]);
		end
	end
	initial begin
		#160000;
		fail_count++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'h6abf7d7d));
		{reset_n, standby, module_standby, reg_wr, reg_rd, nmi_in, err_arm} = 7'h00;
		{reg_addr, reg_wdata, ext_request_pin, lat, sh_single, sh_ackph} = 50'h0;
		{serial_rx_full_req, serial_tx_empty_req, bus_target_excluded} = 3'h0;
		fail_count = 0;
		samples_checked = 0;
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		rc(DGC_OFS_GLOBAL, DGC_GLOBAL_RST);
		rc(ra(1, DGC_OFS_CTRL), {26'h0, DGC_CTRL_RST});
		rc(ra(0, DGC_OFS_COUNT), {8'h0, DGC_COUNT_RST});
		wr(DGC_OFS_GLOBAL, 32'hfffffff9);
		rc(DGC_OFS_GLOBAL, 32'h9);
		rc(8'hf0, 32'h0);
		@(posedge ref_clk);
		module_standby <= 1'b1;
		rc(DGC_OFS_GLOBAL, 32'h9);
		module_standby <= 1'b0;
		standby        <= 1'b1;
		@(posedge ref_clk);
		standby <= 1'b0;
		rc(DGC_OFS_GLOBAL, 32'h0);
		// nmi while idle, then flag protection
		@(posedge ref_clk);
		nmi_in <= 1'b1;
		@(posedge ref_clk);
		nmi_in <= 1'b0;
		rc(DGC_OFS_GLOBAL, 32'h2);
		wr(DGC_OFS_GLOBAL, 32'h3);
		wr(DGC_OFS_GLOBAL, 32'h1);
		rc(DGC_OFS_GLOBAL, 32'h3);
		n = $urandom_range(1, 4);
		lat <= 4'($urandom_range(0, 3));
		setup(0, n, 32'h25, 2'h0);
		wait_idle();
		chk(seq.size(), 0);
		clr(DGC_OFS_GLOBAL, 32'h1);
		wait_idle();
		chk(seq.size(), n);
		rc(ra(0, DGC_OFS_COUNT), 32'h0);
		chk(finish_interrupt, 2'b01);
		rc(ra(0, DGC_OFS_CTRL), 32'h27);
		wr(ra(0, DGC_OFS_CTRL), 32'h27);
		wait_idle();
		chk(seq.size(), n);
		clr(ra(0, DGC_OFS_CTRL), 32'h0);
		// fixed order then round robin, dual and single acknowledge kinds
		for (int m = 0; m < 2; m++) begin
			seq.delete();
			wr(DGC_OFS_GLOBAL, m ? 32'h8 : 32'h0);
			setup(0, 2, m ? 32'h35 : 32'h25, 2'h0);
			setup(1, 2, m ? 32'h2d : 32'h3d, 2'h0);
			wr(DGC_OFS_GLOBAL, m ? 32'h9 : 32'h1);
			wait_idle();
			chk(seq.size(), 4);
			chk({seq[0], seq[1], seq[2], seq[3]}, m ? 4'h5 : 4'h3);
			chk(finish_interrupt, 2'b11);
			clr(ra(0, DGC_OFS_CTRL), 32'h0);
			clr(ra(1, DGC_OFS_CTRL), 32'h0);
		end
		wr(DGC_OFS_GLOBAL, 32'h1);
		// address error in the read phase
		seq.delete();
		err_arm <= 1'b1;
		setup(0, 4, 32'h21, 2'h0);
		wait_idle();
		err_arm <= 1'b0;
		chk(seq.size(), 1);
		rc(ra(0, DGC_OFS_COUNT), 32'h3);
		rc(ra(0, DGC_OFS_CTRL), 32'h21);
		wr(ra(0, DGC_OFS_CTRL), 32'h0);
		clr(DGC_OFS_GLOBAL, 32'h1);
		rc(DGC_OFS_GLOBAL, 32'h1);
		// forbidden endpoint reported at unit start
		bus_target_excluded <= 1'b1;
		setup(0, 2, 32'h21, 2'h0);
		wait_idle();
		chk(seq.size(), 1);
		wr(ra(0, DGC_OFS_CTRL), 32'h0);
		rc(DGC_OFS_GLOBAL, 32'h5);
		wr(DGC_OFS_GLOBAL, 32'h1);
		bus_target_excluded <= 1'b0;
		// master gate cleared during a slow unit
		seq.delete();
		lat <= 4'h8;
		setup(0, 5, 32'h21, 2'h0);
		wait_start();
		wr(DGC_OFS_GLOBAL, 32'h0);
		wait_idle();
		chk(seq.size(), 1);
		rc(ra(0, DGC_OFS_COUNT), 32'h5);
		rc(ra(0, DGC_OFS_CTRL), 32'h21);
		wr(ra(0, DGC_OFS_CTRL), 32'h0);
		wr(DGC_OFS_GLOBAL, 32'h1);
		// each request source on channel 1, the others held busy while it is low, then dropped when it is raised
		lat <= 4'h3;
		for (int s = 0; s < 3; s++) begin
			seq.delete();
			n = $urandom_range(2, 6);
			setup(1, n, 32'h01, 2'(s));
			{serial_tx_empty_req, serial_rx_full_req, ext_request_pin[1]} <= ~(3'h1 << s);
			wait_idle();
			chk(seq.size(), 0);
			{serial_tx_empty_req, serial_rx_full_req, ext_request_pin[1]} <= 3'h1 << s;
			wait_start();
			{serial_tx_empty_req, serial_rx_full_req, ext_request_pin[1]} <= 3'h0;
			wait_idle();
			chk(seq.size(), 1);
			rc(ra(1, DGC_OFS_COUNT), n - 1);
			wr(ra(1, DGC_OFS_CTRL), 32'h0);
		end
		end_of_test();
	end
endmodule : dgc_top_tb
